// *** tsd_decoder.sv ***
`timescale 1ns/1ns
`include "tsd_regs.svh"

// Operation
// - Each root thread gets an eight-bit tag unique among running roots.
// - Root tag is used only on dereference; ignored for other operations.
// - Word four bits 15:10 give payload entry count; ignored on dereference.
// - Child spawn initialises payload count plus return-buffer constants registers.
// - Root spawn initialises payload count, constants, plus one buffer handle register.
// - Word four bits 9:0 give payload entry offset; ignored on dereference.
// - Word two bits 31:4 give child kernel pointer; ignored otherwise.
// - Child spawn passes the kernel descriptor pointer on to dispatch.
// - Child spawn takes word zero bits 15:0 as child payload handle.
// - Root spawn takes word zero bits 15:0 as message buffer handle.
// - Dereference with descriptor bit 4 clear dereferences the handle; else ignore it.
// - Descriptor bit 0: zero dereferences resources, one spawns a thread.
// - On spawn, descriptor bit 4 picks child (zero) or root (one).
// - Descriptor bit 1 is caller kind; only root callers release resources.
module tsd_decoder #(
    parameter int ADDR_W = 8,
    parameter int TAGS = 256
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [ADDR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic o_wb_ack,
    output logic [31:0] o_wb_dat,
    input wire logic i_msg_valid,
    input wire tsd_pkg::tsd_desc_t i_msg_desc,
    input wire logic [255:0] i_msg_data,
    output logic o_msg_ready,
    output logic o_disp_valid,
    input wire logic i_disp_ready,
    output tsd_pkg::tsd_disp_t o_disp
);

    typedef enum logic {
        S_IDLE,
        S_SEND
    } tsd_state_t;

    tsd_state_t state_reg;
    tsd_pkg::tsd_disp_t disp_reg;
    tsd_pkg::tsd_disp_t disp_next;
    logic enable_reg;
    logic [5:0] consts_reg;
    logic err_reg;
    logic [31:0] msgcnt_reg;
    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic [31:0] dw_handle;
    logic [31:0] dw_kptr;
    logic [31:0] dw_entry;
    logic [31:0] dw_tag;
    logic is_spawn;
    logic is_root_spawn;
    logic is_child_spawn;
    logic accept;
    logic tag_avail;
    logic [7:0] tag_new;
    logic [8:0] tags_used;
    logic [5:0] cnt_field;
    logic wb_req;
    logic wb_wr;

    // =================================================================
    // Message word slices; the whole message arrives on one bus
    assign dw_handle = i_msg_data[`TSD_DW_HANDLE*`TSD_DW_BITS +: `TSD_DW_BITS];
    assign dw_kptr = i_msg_data[`TSD_DW_KPTR*`TSD_DW_BITS +: `TSD_DW_BITS];
    assign dw_entry = i_msg_data[`TSD_DW_ENTRY*`TSD_DW_BITS +: `TSD_DW_BITS];
    assign dw_tag = i_msg_data[`TSD_DW_TAG*`TSD_DW_BITS +: `TSD_DW_BITS];
    assign cnt_field = dw_entry[`TSD_CNT_MSB:`TSD_CNT_LSB];

    // Operation decode from the descriptor
    assign is_spawn = i_msg_desc.opcode;
    assign is_root_spawn = is_spawn && i_msg_desc.res_sel;
    assign is_child_spawn = is_spawn && !i_msg_desc.res_sel;

    // =================================================================
    // Root spawns stall while no tag is free, so a tag is never shared
    assign o_msg_ready = enable_reg && state_reg == S_IDLE
        && (!is_root_spawn || tag_avail);
    assign accept = i_msg_valid && o_msg_ready;

    tsd_tag_pool #(
        .TAGS(TAGS),
        .TAG_W(8)
    ) u_tags (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_alloc(accept && is_root_spawn),
        .i_free(accept && !is_spawn && !i_msg_desc.caller_child),
        .i_free_tag(dw_tag[`TSD_TAG_MSB:`TSD_TAG_LSB]),
        .o_avail(tag_avail),
        .o_tag(tag_new),
        .o_used_count(tags_used)
    );

    // =================================================================
    // Decoded operation; ignored fields are forced to zero
    always_comb begin
        disp_next = '0;
        disp_next.debug6 = i_msg_data[`TSD_DW_DBG6*`TSD_DW_BITS +: `TSD_DW_BITS];
        disp_next.debug7 = i_msg_data[`TSD_DW_DBG7*`TSD_DW_BITS +: `TSD_DW_BITS];
        if (is_spawn) begin
            disp_next.entry_count = cnt_field;
            disp_next.entry_offset = dw_entry[`TSD_OFS_MSB:`TSD_OFS_LSB];
            disp_next.buffer_handle = dw_handle[`TSD_HANDLE_MSB:`TSD_HANDLE_LSB];
            disp_next.handle_valid = 1'b1;
        end
        if (is_child_spawn) begin
            disp_next.kind = tsd_pkg::TSD_KIND_CHILD;
            disp_next.kernel_ptr = dw_kptr[`TSD_KPTR_MSB:`TSD_KPTR_LSB];
            disp_next.reg_count = 7'(cnt_field) + 7'(consts_reg);
        end else if (is_root_spawn) begin
            disp_next.kind = tsd_pkg::TSD_KIND_ROOT;
            disp_next.reg_count = 7'(cnt_field) + 7'(consts_reg) + 7'h01;
            disp_next.root_tag = tag_new;
        end else begin
            disp_next.kind = tsd_pkg::TSD_KIND_DEREF;
            disp_next.release_ff = !i_msg_desc.caller_child;
            if (!i_msg_desc.caller_child) begin
                disp_next.root_tag = dw_tag[`TSD_TAG_MSB:`TSD_TAG_LSB];
            end
            if (!i_msg_desc.res_sel) begin
                disp_next.buffer_handle = dw_handle[`TSD_HANDLE_MSB:`TSD_HANDLE_LSB];
                disp_next.handle_valid = 1'b1;
            end
        end
    end

    // =================================================================
    // Capture on accept; held until dispatch takes it
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            disp_reg <= '0;
        end else if (accept) begin
            disp_reg <= disp_next;
        end
    end

    // Handshake with dispatch logic
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    if (accept) begin
                        state_reg <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (i_disp_ready) begin
                        state_reg <= S_IDLE;
                    end
                end
            endcase
        end
    end

    assign o_disp_valid = state_reg == S_SEND;
    assign o_disp = disp_reg;

    // =================================================================
    // Root spawn with zero entries is undefined; flag it for software
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            err_reg <= 1'b0;
        end else if (accept && is_root_spawn && cnt_field == 6'h00) begin
            err_reg <= 1'b1;
        end else if (wb_wr && i_wb_adr == ADDR_W'(`TSD_ADDR_STATUS) && i_wb_sel[0]
            && i_wb_dat[`TSD_STAT_ERR_BIT]) begin
            err_reg <= 1'b0;
        end
    end

    // Accepted message counter, wraps
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            msgcnt_reg <= 32'h00000000;
        end else if (accept) begin
            msgcnt_reg <= msgcnt_reg + 32'h00000001;
        end
    end

    // =================================================================
    // Wishbone slave: ack one cycle after the request, one cycle long
    assign wb_req = i_wb_cyc && i_wb_stb;
    assign wb_wr = wb_req && i_wb_we && wb_ack_reg;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= wb_req && !wb_ack_reg;
        end
    end

    // Control writes land on the edge where the master sees ack
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            enable_reg <= `TSD_CTRL_EN_RESET;
            consts_reg <= `TSD_CTRL_CONST_RESET;
        end else if (wb_wr && i_wb_adr == ADDR_W'(`TSD_ADDR_CTRL)) begin
            if (i_wb_sel[0]) begin
                enable_reg <= i_wb_dat[`TSD_CTRL_EN_BIT];
            end
            if (i_wb_sel[1]) begin
                consts_reg <= i_wb_dat[`TSD_CTRL_CONST_MSB:`TSD_CTRL_CONST_LSB];
            end
        end
    end

    // Read data registered so it is stable with ack; unmapped reads zero
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wb_dat_reg <= 32'h00000000;
        end else if (wb_req && !wb_ack_reg) begin
            if (i_wb_adr == ADDR_W'(`TSD_ADDR_CTRL)) begin
                wb_dat_reg <= {18'h00000, consts_reg, 7'h00, enable_reg};
            end else if (i_wb_adr == ADDR_W'(`TSD_ADDR_STATUS)) begin
                wb_dat_reg <= {7'h00, tags_used, 14'h0000, err_reg, o_disp_valid};
            end else if (i_wb_adr == ADDR_W'(`TSD_ADDR_MSGCNT)) begin
                wb_dat_reg <= msgcnt_reg;
            end else begin
                wb_dat_reg <= 32'h00000000;
            end
        end
    end

    assign o_wb_ack = wb_ack_reg;
    assign o_wb_dat = wb_dat_reg;

    // =================================================================
    // Checks on the decoded output, the tag count and the error flag
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_take_child;
        accept && is_child_spawn;
    endsequence

    sequence s_take_root;
        accept && is_root_spawn;
    endsequence

    sequence s_take_deref;
        accept && !is_spawn;
    endsequence

    a_child_regcount: assert property (s_take_child |=> o_disp_valid
        && o_disp.reg_count == 7'($past(cnt_field)) + 7'($past(consts_reg)))
        else $error("child register count wrong");

    a_root_regcount: assert property (s_take_root |=> o_disp_valid
        && o_disp.reg_count == 7'($past(cnt_field)) + 7'($past(consts_reg)) + 7'h01)
        else $error("root register count wrong");

    a_kernel_ptr: assert property (s_take_child |=> o_disp.kernel_ptr
        == $past(dw_kptr[`TSD_KPTR_MSB:`TSD_KPTR_LSB]))
        else $error("kernel pointer not passed");

    a_ptr_ignored: assert property ((accept && !is_child_spawn) |=> o_disp.kernel_ptr == '0
        && o_disp.kind != tsd_pkg::TSD_KIND_CHILD)
        else $error("kernel pointer used outside child spawn");

    a_deref_fields: assert property (s_take_deref |=> o_disp.kind == tsd_pkg::TSD_KIND_DEREF
        && o_disp.entry_count == '0 && o_disp.entry_offset == '0)
        else $error("payload fields used on dereference");

    a_spawn_offset: assert property ((accept && is_spawn) |=> o_disp.entry_offset
        == $past(dw_entry[`TSD_OFS_MSB:`TSD_OFS_LSB]))
        else $error("payload offset not captured");

    a_deref_handle: assert property (s_take_deref |=> o_disp.handle_valid
        == !$past(i_msg_desc.res_sel))
        else $error("handle dereference flag wrong");

    a_release_tag: assert property (s_take_deref |=> o_disp.release_ff
        == !$past(i_msg_desc.caller_child)
        && (o_disp.release_ff || o_disp.root_tag == '0))
        else $error("resource release wrong");

    a_root_tag_held: assert property (s_take_root |-> tag_avail ##1
        tags_used == $past(tags_used) + 9'h001)
        else $error("root tag not reserved");

    a_spawn_tag_clear: assert property (s_take_child |=> o_disp.root_tag == '0)
        else $error("tag used outside dereference");

    a_hold_stable: assert property ((o_disp_valid && !i_disp_ready) |=> o_disp_valid
        && $stable(o_disp))
        else $error("dispatch changed before taken");

    a_root_zero_err: assert property ((s_take_root and (cnt_field == 6'h00)) |=> err_reg)
        else $error("zero-length root not flagged");

endmodule

// *** tsd_regs.svh ***
`ifndef TSD_REGS_SVH
`define TSD_REGS_SVH

// =====================================================================
// Message doubleword numbers
`define TSD_DW_HANDLE 0
`define TSD_DW_KPTR 2
`define TSD_DW_ENTRY 4
`define TSD_DW_TAG 5
`define TSD_DW_DBG6 6
`define TSD_DW_DBG7 7
`define TSD_DW_BITS 32

// =====================================================================
// Field positions inside the doublewords
`define TSD_HANDLE_MSB 15
`define TSD_HANDLE_LSB 0
`define TSD_KPTR_MSB 31
`define TSD_KPTR_LSB 4
`define TSD_CNT_MSB 15
`define TSD_CNT_LSB 10
`define TSD_OFS_MSB 9
`define TSD_OFS_LSB 0
`define TSD_TAG_MSB 7
`define TSD_TAG_LSB 0

// =====================================================================
// Register byte addresses and fields
`define TSD_ADDR_CTRL 8'h00
`define TSD_ADDR_STATUS 8'h04
`define TSD_ADDR_MSGCNT 8'h08
`define TSD_CTRL_EN_BIT 0
`define TSD_CTRL_CONST_MSB 13
`define TSD_CTRL_CONST_LSB 8
`define TSD_CTRL_EN_RESET 1'h1
`define TSD_CTRL_CONST_RESET 6'h00
`define TSD_STAT_ERR_BIT 1

`endif

// *** tsd_pkg.sv ***
package tsd_pkg;

    // =================================================================
    // Descriptor bits 4:0 of the send operation
    typedef struct packed {
        logic res_sel;
        logic [1:0] rsvd;
        logic caller_child;
        logic opcode;
    } tsd_desc_t;

    typedef enum logic [1:0] {
        TSD_KIND_DEREF,
        TSD_KIND_CHILD,
        TSD_KIND_ROOT
    } tsd_kind_t;

    // Decoded operation handed to dispatch logic
    typedef struct packed {
        tsd_kind_t kind;
        logic [6:0] reg_count;
        logic [5:0] entry_count;
        logic [9:0] entry_offset;
        logic [27:0] kernel_ptr;
        logic [15:0] buffer_handle;
        logic handle_valid;
        logic release_ff;
        logic [7:0] root_tag;
        logic [31:0] debug6;
        logic [31:0] debug7;
    } tsd_disp_t;

endpackage

// *** tsd_tag_pool.sv ***
`timescale 1ns/1ns
module tsd_tag_pool #(
    parameter int TAGS = 256,
    parameter int TAG_W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_alloc,
    input wire logic i_free,
    input wire logic [TAG_W-1:0] i_free_tag,
    output logic o_avail,
    output logic [TAG_W-1:0] o_tag,
    output logic [TAG_W:0] o_used_count
);

    logic [TAGS-1:0] used_reg;
    logic [TAG_W:0] count_reg;
    logic free_hit;

    // =================================================================
    // Lowest free tag; searching downward leaves the lowest one last
    always_comb begin
        o_avail = 1'b0;
        o_tag = '0;
        for (int i = TAGS - 1; i >= 0; i--) begin
            if (!used_reg[i]) begin
                o_avail = 1'b1;
                o_tag = TAG_W'(i);
            end
        end
    end

    // Freeing a tag that is not held is ignored
    assign free_hit = i_free && used_reg[i_free_tag];

    // =================================================================
    // One in-use flag per tag; allocation wins over a same-cycle free
    for (genvar g = 0; g < TAGS; g++) begin : g_slot
        always_ff @(posedge i_clock) begin
            if (i_rst) begin
                used_reg[g] <= 1'b0;
            end else if (i_alloc && o_avail && o_tag == TAG_W'(g)) begin
                used_reg[g] <= 1'b1;
            end else if (free_hit && i_free_tag == TAG_W'(g)) begin
                used_reg[g] <= 1'b0;
            end
        end
    end

    // Count of tags held by running root threads
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            count_reg <= '0;
        end else if ((i_alloc && o_avail) && !free_hit) begin
            count_reg <= count_reg + 1'b1;
        end else if (!(i_alloc && o_avail) && free_hit) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign o_used_count = count_reg;

endmodule

// *** tsd_sender.sv ***
`timescale 1ns/1ns

// =====================================================================
// Thread side: offers one message (spawn or dereference) at a time
module tsd_sender (
    input wire logic i_clock,
    input wire logic i_ready,
    output logic o_valid,
    output tsd_pkg::tsd_desc_t o_desc,
    output logic [255:0] o_data
);
    logic [255:0] msg;

    // Idle lines at time zero
    initial begin
        o_valid = 1'b0;
        o_desc = '0;
        o_data = '0;
    end

    // Offer after gap idle cycles; hold until taken or the limit runs out
    task automatic send(input logic [4:0] d, input logic [31:0] w0, w2, w4, w5, h6, h7,
                        input int gap, input int limit, output logic ok);
        int n;
        begin
            n = 0;
            // Header words six and seven go in the debug slots
            msg = {h7, h6, w5, w4, 32'hFFFF_FFFF, w2, 32'hFFFF_FFFF, w0};
            repeat (gap + 1) @(posedge i_clock);
            o_valid <= 1'b1;
            o_desc <= d;
            o_data <= msg; // Whole message in one word
            do begin
                @(posedge i_clock);
                n++;
            end while (i_ready !== 1'b1 && n < limit);
            ok = i_ready;
            // Released lines show the inverse, so stale data cannot pass as captured
            o_valid <= 1'b0;
            o_desc <= ~d;
            o_data <= ~msg;
        end
    endtask
endmodule

// *** tsd_decoder_tb.sv ***
`timescale 1ns/1ns

module tsd_decoder_tb;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic ack;
    logic [31:0] rdat;
    logic msg_valid;
    logic msg_ready;
    logic disp_valid;
    logic disp_ready = 1'b0;
    tsd_pkg::tsd_desc_t msg_desc;
    logic [255:0] msg_data;
    tsd_pkg::tsd_disp_t disp;
    tsd_pkg::tsd_disp_t e;
    logic [31:0] q;
    logic ok;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    // =================================================================
    // Clock, design and thread model
    always #50 i_clock = ~i_clock;

    tsd_decoder uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_ack(ack), .o_wb_dat(rdat), .i_msg_valid(msg_valid),
        .i_msg_desc(msg_desc), .i_msg_data(msg_data), .o_msg_ready(msg_ready),
        .o_disp_valid(disp_valid), .i_disp_ready(disp_ready), .o_disp(disp)
    );

    tsd_sender snd (
        .i_clock(i_clock), .i_ready(msg_ready), .o_valid(msg_valid),
        .o_desc(msg_desc), .o_data(msg_data)
    );

    // =================================================================
    // Reporting
    task automatic chk(input logic [159:0] got, input logic [159:0] exp);
        begin
            check_count++;
            if (got !== exp) begin
                n_mismatch++;
                $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task automatic conclude();
        begin
            $display("checks %0d mismatches %0d", check_count, n_mismatch);
            if (n_mismatch == 0 && check_count > 0) begin
                $display("No errors found");
            end else begin
                $display("Errors were found");
            end
            $finish;
        end
    endtask

    // A hang counts as a mismatch
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    // =================================================================
    // Bus and message helpers
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        begin
            @(posedge i_clock);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= d;
            sel <= s;
            // Only the bench timeout ends this wait
            do begin
                @(posedge i_clock);
            end while (ack !== 1'b1);
            r = rdat;
            chk(ack, 1'b1);
            cyc <= 1'b0;
            @(posedge i_clock);
        end
    endtask

    // Send one message, then judge the decoded operation and its handshake
    task automatic op(input logic [4:0] d, input logic [31:0] w0, w2, w4, w5,
                      input int gap, input tsd_pkg::tsd_disp_t ex);
        logic [31:0] h6;
        begin
            h6 = 32'h6600_0000 + 32'(check_count);
            ex.debug6 = h6;
            ex.debug7 = ~h6;
            snd.send(d, w0, w2, w4, w5, h6, ~h6, gap, 40, ok);
            chk(ok, 1'b1);
            disp_ready <= 1'b1;
            @(negedge i_clock);
            // Spawns always carry their handle and never release root resources
            if (ex.kind != tsd_pkg::TSD_KIND_DEREF) begin
                ex.handle_valid = 1'b1;
                ex.release_ff = 1'b0;
            end
            chk(disp_valid, 1'b1);
            chk(disp, ex);
            @(posedge i_clock);
            disp_ready <= 1'b0;
            @(negedge i_clock);
            chk(disp_valid, 1'b0);
        end
    endtask

    // =================================================================
    // Scenarios
    task automatic t_regs();
        begin
            wb(1'b0, 8'h00, 32'h0, 4'hF, q);
            chk(q, 32'h0000_0001);
            wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF, q);
            wb(1'b0, 8'h0C, 32'h0, 4'hF, q);
            chk(q, 32'h0);
            // Constants byte alone; enable must survive
            wb(1'b1, 8'h00, 32'h0000_0300, 4'h2, q);
            wb(1'b0, 8'h00, 32'h0, 4'hF, q);
            chk(q, 32'h0000_0301);
        end
    endtask

    task automatic t_refuse();
        begin
            wb(1'b1, 8'h00, 32'h0, 4'h1, q);
            snd.send(5'h01, 32'h0, 32'h0, 32'h0000_0400, 32'h0, 32'h0, 32'h0, 0, 6, ok);
            chk(ok, 1'b0);
            wb(1'b1, 8'h00, 32'h0000_0301, 4'hF, q);
        end
    endtask

    task automatic t_spawn();
        begin
            e = '0;
            e.kind = tsd_pkg::TSD_KIND_CHILD;
            e.reg_count = 7'h03;
            e.entry_offset = 10'h3FF;
            e.kernel_ptr = 28'h123_4567;
            e.buffer_handle = 16'h1234;
            op(5'h01, 32'hFFAB_1234, 32'h1234_567F, 32'hFFFF_03FF, 32'hA5, 0, e);
            e.kind = tsd_pkg::TSD_KIND_ROOT;
            e.reg_count = 7'h43;
            e.entry_count = 6'h3F;
            e.entry_offset = 10'h005;
            e.kernel_ptr = 28'h0;
            e.buffer_handle = 16'h00C3;
            op(5'h11, 32'hFF00_00C3, 32'hFFFF_FFF0, 32'h0000_FC05, 32'hA5, 3, e);
            e.reg_count = 7'h05;
            e.entry_count = 6'h01;
            e.entry_offset = 10'h000;
            e.root_tag = 8'h01;
            op(5'h11, 32'h0000_00C3, 32'h0, 32'h0000_0400, 32'h0, 0, e);
            wb(1'b0, 8'h04, 32'h0, 4'hF, q);
            chk(q, 32'h0002_0000);
            wb(1'b0, 8'h08, 32'h0, 4'hF, q);
            chk(q, 32'h0000_0003);
        end
    endtask

    task automatic t_deref();
        begin
            e = '0;
            e.kind = tsd_pkg::TSD_KIND_DEREF;
            e.buffer_handle = 16'hBEEF;
            e.handle_valid = 1'b1;
            e.release_ff = 1'b1;
            op(5'h00, 32'hFF00_BEEF, '1, '1, 32'hFFFF_FF00, 0, e);
            wb(1'b0, 8'h04, 32'h0, 4'hF, q);
            chk(q, 32'h0001_0000);
            e.buffer_handle = 16'h0;
            e.handle_valid = 1'b0;
            e.release_ff = 1'b0;
            op(5'h12, 32'hFF00_BEEF, '1, '1, 32'hFFFF_FF01, 2, e);
            // Freed tag zero is the lowest free one again
            e.kind = tsd_pkg::TSD_KIND_ROOT;
            e.reg_count = 7'h05;
            e.entry_count = 6'h01;
            e.buffer_handle = 16'h0042;
            op(5'h11, 32'h0000_0042, 32'h0, 32'h0000_0400, 32'hFF, 0, e);
            wb(1'b0, 8'h04, 32'h0, 4'hF, q);
            chk(q, 32'h0002_0000);
        end
    endtask

    // Zero-length root is dispatched but flagged; a root caller may keep its handle
    task automatic t_zero();
        begin
            e = '0;
            e.kind = tsd_pkg::TSD_KIND_ROOT;
            e.reg_count = 7'h04;
            e.entry_offset = 10'h007;
            e.buffer_handle = 16'h0077;
            e.root_tag = 8'h02;
            op(5'h11, 32'h0000_0077, 32'h0, 32'h0000_0007, 32'h0, 0, e);
            wb(1'b0, 8'h04, 32'h0, 4'hF, q);
            chk(q, 32'h0003_0002);
            e = '0;
            e.kind = tsd_pkg::TSD_KIND_DEREF;
            e.release_ff = 1'b1;
            e.root_tag = 8'h02;
            op(5'h10, 32'h0000_ABCD, '1, '1, 32'h0000_0002, 1, e);
            // Write one to clear the sticky error
            wb(1'b1, 8'h04, 32'h0000_0002, 4'h1, q);
            wb(1'b0, 8'h04, 32'h0, 4'hF, q);
            chk(q, 32'h0002_0000);
        end
    endtask

    // =================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        t_regs();
        t_refuse();
        t_spawn();
        t_deref();
        t_zero();
        conclude();
    end
endmodule
